// >>> raf_defines.svh
// Purpose: named constants of the reader framing host controller
// Assumes: device register map reached over a four-wire serial port
// Notes: timing counts derive from times and the 8 ns clock period
`ifndef RAF_DEFINES_SVH
`define RAF_DEFINES_SVH

// serial header: top two bits select the access kind
`define RAF_HDR_WR 2'h0
`define RAF_HDR_RD 2'h1
`define RAF_HDR_LOAD 8'h80

// device register addresses
`define RAF_REG_AUX 6'h01
`define RAF_REG_OPCTL 6'h02
`define RAF_REG_MODE 6'h03
`define RAF_REG_RATE 6'h04
`define RAF_REG_ANTCL 6'h05
`define RAF_REG_FSET 6'h06
`define RAF_REG_MRT 6'h0F
`define RAF_REG_NRT1 6'h10
`define RAF_REG_NRT2 6'h11
`define RAF_REG_IRQ 6'h1A
`define RAF_REG_TXB1 6'h1D
`define RAF_REG_TXB2 6'h1E
`define RAF_REG_FIFO 6'h3F

// register values
`define RAF_MODE_A 8'h08
`define RAF_MODE_F 8'h20
`define RAF_RATE_106 8'h00
`define RAF_RATE_212 8'h11
`define RAF_RATE_424 8'h22
`define RAF_ANTCL_ON 8'h01
`define RAF_NOCRC_ON 8'h80
`define RAF_OFF 8'h00
`define RAF_OPCTL_ON 8'hC8
`define RAF_PRE_48 2'h0
`define RAF_IRQ_NRE_BIT 3'h0
`define RAF_IRQ_NRE_MASK 8'h01

// direct command codes
`define RAF_DC_CLEAR 8'hC2
`define RAF_DC_TXCRC 8'hC4
`define RAF_DC_TXNOCRC 8'hC5
`define RAF_DC_REQA 8'hC6
`define RAF_DC_WUPA 8'hC7
`define RAF_DC_PRESET 8'hCC

// frame delay in carrier periods, mask timer step in carrier periods
`define RAF_FC_FDT_ONE 16'h04D4
`define RAF_FC_FDT_ZERO 16'h0494
`define RAF_FC_MRT_STEP 16'h0040
`define RAF_MRT_VAL ((`RAF_FC_FDT_ZERO - 16'h0001) / `RAF_FC_MRT_STEP)
`define RAF_NRT_VAL (`RAF_FC_FDT_ONE / `RAF_FC_MRT_STEP + 16'h0002)

// field guard time in ns and its clock count, rounded up
`define RAF_GUARD_NS 32'h004C_4B40
`define RAF_CLK_NS 32'h0000_0008
`define RAF_GUARD_CYC ((`RAF_GUARD_NS + `RAF_CLK_NS - 32'h0000_0001) / `RAF_CLK_NS)
`define RAF_CNT_W 20
`define RAF_SPI_DIV 8'h04

`endif

// >>> raf_pkg.sv
// Purpose: types of the reader framing host controller
// Assumes: raf_defines.svh gives the widths
// Notes: sequencer and serial engine state travel as packed structs
`include "raf_defines.svh"
package raf_pkg;

	// user commands
	typedef enum logic [2:0] {
		RAF_C_SETUP = 3'h0,
		RAF_C_REQA = 3'h1,
		RAF_C_WUPA = 3'h2,
		RAF_C_ANTICOL = 3'h3,
		RAF_C_SELECT = 3'h4,
		RAF_C_TYPEF = 3'h5,
		RAF_C_RDFIFO = 3'h6
	} raf_cmd_type;

	// kinds of micro step
	typedef enum logic [2:0] {
		RAF_K_END = 3'h0,
		RAF_K_WR = 3'h1,
		RAF_K_CMD = 3'h2,
		RAF_K_LOAD = 3'h3,
		RAF_K_READ = 3'h4,
		RAF_K_GUARD = 3'h5,
		RAF_K_IRQW = 3'h6
	} raf_kind_type;

	// sequencer states
	typedef enum logic [2:0] {
		RAF_S_IDLE = 3'h0,
		RAF_S_FETCH = 3'h1,
		RAF_S_HDR = 3'h2,
		RAF_S_DATA = 3'h3,
		RAF_S_LOADB = 3'h4,
		RAF_S_LOADW = 3'h5,
		RAF_S_GUARD = 3'h6,
		RAF_S_IRQW = 3'h7
	} raf_st_type;

	// one micro step
	typedef struct packed {
		raf_kind_type kind;
		logic [5:0] addr;
		logic [7:0] data;
	} raf_op_type;

	// byte request to the serial engine
	typedef struct packed {
		logic go;
		logic hold;
		logic [7:0] data;
	} raf_req_type;

	// serial engine state
	typedef struct packed {
		logic busy;
		logic hold;
		logic phase;
		logic [2:0] bitn;
		logic [7:0] div;
		logic [7:0] sh;
		logic [7:0] rx;
		logic [7:0] rx_out;
		logic done;
		logic sclk;
		logic mosi;
		logic cs_n;
	} raf_spi_type;

	// sequencer state
	typedef struct packed {
		raf_st_type st;
		raf_cmd_type cmd;
		logic [4:0] idx;
		logic [7:0] sub;
		logic [`RAF_CNT_W-1:0] cnt;
		logic [7:0] sel;
		logic [7:0] nvb;
		logic [39:0] uid;
		logic [7:0] tf_len;
		logic rate424;
		logic [1:0] pre;
		logic [2:0] rx_bits;
		logic [7:0] rdata;
		logic tag;
		logic noans;
		logic done;
		raf_req_type req;
	} raf_main_type;

endpackage : raf_pkg

// >>> raf_spi_eng.sv
// Purpose: byte engine of the serial port toward the device
// Assumes: device samples on rising clock edge, chip select low active
// Notes: hold keeps chip select low after the byte
`timescale 1ns/1ns
module raf_spi_eng import raf_pkg::*; #(
	parameter logic [7:0] DIV = `RAF_SPI_DIV
) (
	input wire logic clk,
	input wire logic rst,
	input wire raf_req_type req,
	output logic done,
	output logic [7:0] rx_data,
	output logic spi_sclk,
	output logic spi_mosi,
	output logic spi_cs_n,
	input wire logic spi_miso
);

	raf_spi_type s_r; // registered state
	raf_spi_type s_nxt; // next state

	////////////////////////////////////////////////////////////////////////////
	// next state: one bit per two ticks of the divider
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (s_r.busy) begin
			// divider gives a one-cycle tick
			s_nxt.div = (s_r.div == 8'h00) ? DIV - 8'h01 : s_r.div - 8'h01;
		end
		if (!s_r.busy && req.go) begin
			// load byte, drop chip select, present msb
			s_nxt.busy = 1'b1;
			s_nxt.sh = req.data;
			s_nxt.hold = req.hold;
			s_nxt.cs_n = 1'b0;
			s_nxt.bitn = 3'h7;
			s_nxt.phase = 1'b0;
			s_nxt.div = DIV - 8'h01;
			s_nxt.mosi = req.data[7];
		end else if (s_r.busy && s_r.div == 8'h00) begin
			if (!s_r.phase) begin
				// rising edge: device takes mosi
				s_nxt.sclk = 1'b1;
				s_nxt.phase = 1'b1;
			end else begin
				// falling edge: take miso
				s_nxt.sclk = 1'b0;
				s_nxt.rx = {s_r.rx[6:0], spi_miso};
				s_nxt.phase = 1'b0;
				if (s_r.bitn == 3'h0) begin
					s_nxt.busy = 1'b0;
					s_nxt.done = 1'b1;
					s_nxt.rx_out = {s_r.rx[6:0], spi_miso};
					s_nxt.cs_n = !s_r.hold;
				end else begin
					s_nxt.bitn = s_r.bitn - 3'h1;
					s_nxt.sh = {s_r.sh[6:0], 1'b0};
					s_nxt.mosi = s_r.sh[6];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.cs_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from flops
	assign done = s_r.done;
	assign rx_data = s_r.rx_out;
	assign spi_sclk = s_r.sclk;
	assign spi_mosi = s_r.mosi;
	assign spi_cs_n = s_r.cs_n;

endmodule : raf_spi_eng

// >>> raf_host_ctrl.sv
// Purpose: host sequencer driving a contactless reader front end
// Assumes: device registers, fifo and direct commands behind the serial port
// Notes: one user command runs a fixed list of register steps
// Functional notes
// - select type A, both rates 106 kbps
// - collision bit set only for setup and request/anticollision
// - mask timer below delay, no-answer above
// - timers respect 1236 or 1172 delay
// - hold field about 5 ms first
// - no-CRC receive set by setup and before request/anticollision only
// - any irq except no-answer means tag
// - loop request, anticollision, select; the sequencer runs one command per user request and the user walks the loop
// - select code, valid count, 0-40 UID bits
// - anticollision without CRC, select with CRC
// - pad partial bytes zero, mask read bits
// - load payload only, write byte count
`timescale 1ns/1ns
module raf_host_ctrl import raf_pkg::*; #(
	parameter logic [`RAF_CNT_W-1:0] GUARD_CYC = `RAF_CNT_W'(`RAF_GUARD_CYC),
	parameter logic [7:0] SPI_DIV = `RAF_SPI_DIV
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire raf_cmd_type cmd_code,
	input wire logic [7:0] sel_code,
	input wire logic [7:0] valid_cnt,
	input wire logic [39:0] uid_bits,
	input wire logic [7:0] tf_len,
	input wire logic rate424,
	input wire logic preamble_len_sel_hi,
	input wire logic preamble_len_sel_lo,
	input wire logic [2:0] rx_bits,
	input wire logic pay_valid,
	output logic pay_ready,
	input wire logic [7:0] pay_data,
	output logic done,
	output logic tag_present,
	output logic no_answer,
	output logic [7:0] rd_data,
	output logic spi_sclk,
	output logic spi_mosi,
	output logic spi_cs_n,
	input wire logic spi_miso,
	input wire logic dev_irq
);

	raf_main_type s_r; // registered state
	raf_main_type s_nxt; // next state
	raf_op_type op_w; // current micro step
	logic eng_done; // engine finished a byte
	logic [7:0] eng_rx; // byte read from device
	logic is_tf; // type F transfer
	logic [3:0] full_b; // full bytes of an anticollision frame
	logic [2:0] part_b; // bits of the trailing byte
	logic [7:0] ld_n; // bytes to load
	logic [12:0] tx_cnt; // full byte count for the device
	logic ld_last; // current load byte is the last
	logic [39:0] uid_sh; // uid shifted to current byte
	logic [7:0] ld_byte; // current load byte

	////////////////////////////////////////////////////////////////////////////
	// helpers
	function automatic raf_op_type mk(raf_kind_type k, logic [5:0] a, logic [7:0] d);
		raf_op_type o;
		o.kind = k;
		o.addr = a;
		o.data = d;
		return o;
	endfunction : mk

	function automatic logic [7:0] low_mask(logic [2:0] b);
		return 8'((9'h001 << b) - 9'h001);
	endfunction : low_mask

	// step list of each user command
	function automatic raf_op_type op_at(raf_main_type s, logic [7:0] hi, logic [7:0] lo);
		raf_op_type o;
		logic anti;
		logic [7:0] rate;
		anti = (s.cmd == RAF_C_ANTICOL);
		rate = s.rate424 ? `RAF_RATE_424 : `RAF_RATE_212;
		o = mk(RAF_K_END, 6'h00, 8'h00);
		case (s.cmd)
			RAF_C_SETUP: begin
				case (s.idx)
					5'h0: o = mk(RAF_K_WR, `RAF_REG_MODE, `RAF_MODE_A);
					5'h1: o = mk(RAF_K_WR, `RAF_REG_RATE, `RAF_RATE_106);
					5'h2: o = mk(RAF_K_WR, `RAF_REG_ANTCL, `RAF_ANTCL_ON);
					5'h3: o = mk(RAF_K_WR, `RAF_REG_AUX, `RAF_NOCRC_ON);
					5'h4: o = mk(RAF_K_WR, `RAF_REG_MRT, 8'(`RAF_MRT_VAL));
					5'h5: o = mk(RAF_K_WR, `RAF_REG_NRT1, 8'((`RAF_NRT_VAL) >> 8));
					5'h6: o = mk(RAF_K_WR, `RAF_REG_NRT2, 8'(`RAF_NRT_VAL));
					5'h7: o = mk(RAF_K_CMD, 6'h00, `RAF_DC_PRESET);
					5'h8: o = mk(RAF_K_WR, `RAF_REG_OPCTL, `RAF_OPCTL_ON);
					5'h9: o = mk(RAF_K_GUARD, 6'h00, 8'h00);
					default: o = mk(RAF_K_END, 6'h00, 8'h00);
				endcase
			end
			RAF_C_REQA, RAF_C_WUPA: begin
				case (s.idx)
					5'h0: o = mk(RAF_K_WR, `RAF_REG_ANTCL, `RAF_ANTCL_ON);
					5'h1: o = mk(RAF_K_WR, `RAF_REG_AUX, `RAF_NOCRC_ON);
					5'h2: o = mk(RAF_K_CMD, 6'h00,
						(s.cmd == RAF_C_REQA) ? `RAF_DC_REQA : `RAF_DC_WUPA);
					5'h3: o = mk(RAF_K_IRQW, 6'h00, 8'h00);
					5'h4: o = mk(RAF_K_READ, `RAF_REG_IRQ, 8'h00);
					default: o = mk(RAF_K_END, 6'h00, 8'h00);
				endcase
			end
			RAF_C_ANTICOL, RAF_C_SELECT: begin
				case (s.idx)
					5'h0: o = mk(RAF_K_WR, `RAF_REG_ANTCL,
						anti ? `RAF_ANTCL_ON : `RAF_OFF);
					5'h1: o = mk(RAF_K_WR, `RAF_REG_AUX,
						anti ? `RAF_NOCRC_ON : `RAF_OFF);
					5'h2: o = mk(RAF_K_CMD, 6'h00, `RAF_DC_CLEAR);
					5'h3: o = mk(RAF_K_WR, `RAF_REG_TXB1, hi);
					5'h4: o = mk(RAF_K_WR, `RAF_REG_TXB2, lo);
					5'h5: o = mk(RAF_K_LOAD, 6'h00, 8'h00);
					5'h6: o = mk(RAF_K_CMD, 6'h00,
						anti ? `RAF_DC_TXNOCRC : `RAF_DC_TXCRC);
					5'h7: o = mk(RAF_K_IRQW, 6'h00, 8'h00);
					5'h8: o = mk(RAF_K_READ, `RAF_REG_IRQ, 8'h00);
					default: o = mk(RAF_K_END, 6'h00, 8'h00);
				endcase
			end
			RAF_C_TYPEF: begin
				case (s.idx)
					5'h0: o = mk(RAF_K_WR, `RAF_REG_MODE, `RAF_MODE_F);
					5'h1: o = mk(RAF_K_WR, `RAF_REG_RATE, rate);
					5'h2: o = mk(RAF_K_WR, `RAF_REG_FSET, {6'h00, s.pre});
					5'h3: o = mk(RAF_K_WR, `RAF_REG_ANTCL, `RAF_OFF);
					5'h4: o = mk(RAF_K_WR, `RAF_REG_AUX, `RAF_OFF);
					5'h5: o = mk(RAF_K_CMD, 6'h00, `RAF_DC_CLEAR);
					5'h6: o = mk(RAF_K_WR, `RAF_REG_TXB1, hi);
					5'h7: o = mk(RAF_K_WR, `RAF_REG_TXB2, lo);
					5'h8: o = mk(RAF_K_LOAD, 6'h00, 8'h00);
					5'h9: o = mk(RAF_K_CMD, 6'h00, `RAF_DC_TXCRC);
					5'hA: o = mk(RAF_K_IRQW, 6'h00, 8'h00);
					5'hB: o = mk(RAF_K_READ, `RAF_REG_IRQ, 8'h00);
					default: o = mk(RAF_K_END, 6'h00, 8'h00);
				endcase
			end
			RAF_C_RDFIFO: begin
				if (s.idx == 5'h0) begin
					o = mk(RAF_K_READ, `RAF_REG_FIFO, 8'h00);
				end
			end
			default: o = mk(RAF_K_END, 6'h00, 8'h00);
		endcase
		return o;
	endfunction : op_at

	////////////////////////////////////////////////////////////////////////////
	// frame sizes: valid count high nibble is full bytes, low bits partial
	assign is_tf = (s_r.cmd == RAF_C_TYPEF);
	assign full_b = s_r.nvb[7:4];
	assign part_b = s_r.nvb[2:0];
	assign ld_n = is_tf ? s_r.tf_len : {4'h0, full_b} + {7'h00, part_b != 3'h0};
	assign tx_cnt = is_tf ? {5'h00, s_r.tf_len} : {9'h000, full_b};
	assign ld_last = (s_r.sub == ld_n - 8'h01);
	assign uid_sh = s_r.uid >> {s_r.sub - 8'h02, 3'h0};
	assign op_w = op_at(s_r, tx_cnt[12:5], {tx_cnt[4:0], is_tf ? 3'h0 : part_b});

	// load byte: code, count, then uid with zero padding above valid bits
	always_comb begin
		ld_byte = uid_sh[7:0];
		if (is_tf) begin
			ld_byte = pay_data;
		end else if (s_r.sub == 8'h00) begin
			ld_byte = s_r.sel;
		end else if (s_r.sub == 8'h01) begin
			ld_byte = s_r.nvb;
		end else if (ld_last && part_b != 3'h0) begin
			ld_byte = uid_sh[7:0] & low_mask(part_b);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.req.go = 1'b0;
		s_nxt.done = 1'b0;
		case (s_r.st)
			RAF_S_IDLE: begin
				// the user walks the tag loop one command at a time
				if (cmd_valid) begin
					s_nxt.cmd = cmd_code;
					s_nxt.sel = sel_code;
					s_nxt.nvb = valid_cnt;
					s_nxt.uid = uid_bits;
					s_nxt.tf_len = tf_len;
					s_nxt.rate424 = rate424;
					s_nxt.pre = {preamble_len_sel_hi, preamble_len_sel_lo};
					s_nxt.rx_bits = rx_bits;
					s_nxt.idx = 5'h0;
					s_nxt.st = RAF_S_FETCH;
				end
			end
			RAF_S_FETCH: begin
				case (op_w.kind)
					RAF_K_END: begin
						s_nxt.st = RAF_S_IDLE;
						s_nxt.done = 1'b1;
						if (s_r.cmd != RAF_C_SETUP && s_r.cmd != RAF_C_RDFIFO) begin
							// any irq but no-answer counts as a tag
							s_nxt.tag = |(s_r.rdata & ~`RAF_IRQ_NRE_MASK);
							s_nxt.noans = s_r.rdata[`RAF_IRQ_NRE_BIT];
						end
					end
					RAF_K_GUARD: begin
						s_nxt.cnt = GUARD_CYC - `RAF_CNT_W'(1);
						s_nxt.st = RAF_S_GUARD;
					end
					RAF_K_IRQW: s_nxt.st = RAF_S_IRQW;
					default: begin
						// header byte: direct command, write, read or fifo load
						s_nxt.req.go = 1'b1;
						s_nxt.req.hold = (op_w.kind != RAF_K_CMD);
						if (op_w.kind == RAF_K_CMD) begin
							s_nxt.req.data = op_w.data;
						end else if (op_w.kind == RAF_K_LOAD) begin
							s_nxt.req.data = `RAF_HDR_LOAD;
						end else if (op_w.kind == RAF_K_READ) begin
							s_nxt.req.data = {`RAF_HDR_RD, op_w.addr};
						end else begin
							s_nxt.req.data = {`RAF_HDR_WR, op_w.addr};
						end
						s_nxt.st = RAF_S_HDR;
					end
				endcase
			end
			RAF_S_HDR: begin
				if (eng_done) begin
					if (op_w.kind == RAF_K_CMD) begin
						s_nxt.idx = s_r.idx + 5'h1;
						s_nxt.st = RAF_S_FETCH;
					end else if (op_w.kind == RAF_K_LOAD) begin
						s_nxt.sub = 8'h00;
						s_nxt.st = RAF_S_LOADB;
					end else begin
						// data byte, dummy on a read
						s_nxt.req.go = 1'b1;
						s_nxt.req.hold = 1'b0;
						s_nxt.req.data = (op_w.kind == RAF_K_WR) ? op_w.data : 8'h00;
						s_nxt.st = RAF_S_DATA;
					end
				end
			end
			RAF_S_DATA: begin
				if (eng_done) begin
					if (op_w.kind == RAF_K_READ) begin
						s_nxt.rdata = eng_rx;
						if (s_r.cmd == RAF_C_RDFIFO && s_r.rx_bits != 3'h0) begin
							s_nxt.rdata = eng_rx & low_mask(s_r.rx_bits);
						end
					end
					s_nxt.idx = s_r.idx + 5'h1;
					s_nxt.st = RAF_S_FETCH;
				end
			end
			RAF_S_LOADB: begin
				// payload stalls until the user offers a byte
				if (!is_tf || pay_valid) begin
					s_nxt.req.go = 1'b1;
					s_nxt.req.hold = !ld_last;
					s_nxt.req.data = ld_byte;
					s_nxt.st = RAF_S_LOADW;
				end
			end
			RAF_S_LOADW: begin
				if (eng_done) begin
					if (ld_last) begin
						s_nxt.idx = s_r.idx + 5'h1;
						s_nxt.st = RAF_S_FETCH;
					end else begin
						s_nxt.sub = s_r.sub + 8'h01;
						s_nxt.st = RAF_S_LOADB;
					end
				end
			end
			RAF_S_GUARD: begin
				// field on, wait before the first command
				if (s_r.cnt == `RAF_CNT_W'(0)) begin
					s_nxt.idx = s_r.idx + 5'h1;
					s_nxt.st = RAF_S_FETCH;
				end else begin
					s_nxt.cnt = s_r.cnt - `RAF_CNT_W'(1);
				end
			end
			RAF_S_IRQW: begin
				if (dev_irq) begin
					s_nxt.idx = s_r.idx + 5'h1;
					s_nxt.st = RAF_S_FETCH;
				end
			end
			default: s_nxt.st = RAF_S_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// serial byte engine
	raf_spi_eng #(.DIV(SPI_DIV)) u_eng (
		.clk(clk),
		.rst(rst),
		.req(s_r.req),
		.done(eng_done),
		.rx_data(eng_rx),
		.spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi),
		.spi_cs_n(spi_cs_n),
		.spi_miso(spi_miso)
	);

	assign cmd_ready = (s_r.st == RAF_S_IDLE);
	assign pay_ready = (s_r.st == RAF_S_LOADB) && is_tf;
	assign done = s_r.done;
	assign tag_present = s_r.tag;
	assign no_answer = s_r.noans;
	assign rd_data = s_r.rdata;

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	logic [`RAF_CNT_W-1:0] g_cnt; // cycles spent in guard
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			g_cnt <= '0;
		end else begin
			g_cnt <= (s_r.st == RAF_S_GUARD) ? g_cnt + `RAF_CNT_W'(1) : '0;
		end
	end

	sequence wr_to(logic [5:0] a);
		s_r.st == RAF_S_FETCH && op_w.kind == RAF_K_WR && op_w.addr == a;
	endsequence
	sequence byte_issue;
		s_r.req.go ##1 !s_r.req.go;
	endsequence

	antcl_value_a: assert property (wr_to(`RAF_REG_ANTCL) |-> op_w.data ==
		((s_r.cmd inside {RAF_C_SETUP, RAF_C_REQA, RAF_C_WUPA, RAF_C_ANTICOL})
		? `RAF_ANTCL_ON : `RAF_OFF)) else $error("collision bit wrong for command");
	nocrc_value_a: assert property (wr_to(`RAF_REG_AUX) |-> op_w.data ==
		((s_r.cmd inside {RAF_C_SETUP, RAF_C_REQA, RAF_C_WUPA, RAF_C_ANTICOL})
		? `RAF_NOCRC_ON : `RAF_OFF)) else $error("no-crc bit wrong for command");
	rate_default_a: assert property (wr_to(`RAF_REG_RATE) ##0 (s_r.cmd == RAF_C_SETUP)
		|-> op_w.data == `RAF_RATE_106) else $error("setup rate not 106");
	mask_timer_a: assert property (wr_to(`RAF_REG_MRT) |->
		{8'h00, op_w.data} * `RAF_FC_MRT_STEP < `RAF_FC_FDT_ZERO) else $error("mask timer too long");
	guard_len_a: assert property ($fell(s_r.st == RAF_S_GUARD) |->
		$past(g_cnt) == GUARD_CYC - `RAF_CNT_W'(1)) else $error("guard time wrong");
	crc_cmd_a: assert property (s_r.st == RAF_S_FETCH && op_w.kind == RAF_K_CMD &&
		s_r.cmd inside {RAF_C_ANTICOL, RAF_C_SELECT} && s_r.idx == 5'h6 |=> s_r.req.data ==
		((s_r.cmd == RAF_C_ANTICOL) ? `RAF_DC_TXNOCRC : `RAF_DC_TXCRC)) else $error("wrong tx command");
	pad_zero_a: assert property (s_r.st == RAF_S_LOADW && s_r.req.go && !is_tf && ld_last &&
		part_b != 3'h0 |-> (s_r.req.data & ~low_mask(part_b)) == 8'h00) else $error("pad bits not zero");
	uid_span_a: assert property (s_r.st == RAF_S_LOADB && !is_tf |-> ld_n <= 8'h07)
		else $error("anticollision frame too long");
	tag_report_a: assert property (s_r.done && s_r.cmd inside {RAF_C_REQA, RAF_C_WUPA} |->
		tag_present == |(rd_data & ~`RAF_IRQ_NRE_MASK)) else $error("tag presence misreported");
	tf_count_a: assert property (wr_to(`RAF_REG_TXB2) ##0 is_tf |->
		op_w.data[7:3] == s_r.tf_len[4:0]) else $error("type f count wrong");
	byte_answer_a: assert property (byte_issue |-> ##[1:300] eng_done)
		else $error("serial byte never finished");

endmodule : raf_host_ctrl

// >>> raf_dev_model.sv
// Purpose: behavioural device behind the serial port of the host sequencer
// Assumes: mode 0 serial, header top bits 00 write, 01 read, 11 command
// Notes: interrupt rises a set delay after a transmit command
`timescale 1ns/1ns
module raf_dev_model (
	input wire logic clk,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	input wire logic spi_cs_n,
	output logic spi_miso,
	output logic dev_irq,
	input wire logic [7:0] irq_val,
	input wire logic [7:0] rx_byte,
	input wire logic [7:0] irq_dly
);
	logic [7:0] regs [0:63]; // register file
	logic [7:0] fifo_q [$]; // loaded transmit bytes
	logic [7:0] last_dc; // last direct command
	logic [7:0] sh, osh, hdr; // shifters and header
	logic [3:0] nb; // bits of this byte
	logic [7:0] nby; // bytes of this transaction
	logic miso_r, txp; // output bit, transmit pending
	// a released line shows the inverse of its last value
	assign spi_miso = spi_cs_n ? ~miso_r : miso_r;
	initial begin
		{nb, nby, osh, last_dc, miso_r, txp, dev_irq} = '0;
	end
	// new transaction
	always @(negedge spi_cs_n) begin
		nb = 4'h0;
		nby = 8'h00;
	end
	// shift on rising clock, decode each whole byte
	always @(posedge spi_sclk) begin
		miso_r <= osh[7];
		osh = {osh[6:0], 1'b0};
		sh = {sh[6:0], spi_mosi};
		nb = nb + 4'h1;
		if (nb == 4'h8) begin
			nb = 4'h0;
			if (nby == 8'h00) begin
				hdr = sh;
				if (sh == 8'hC2) fifo_q.delete();
				if (sh[7:6] == 2'h3) last_dc = sh;
				if (sh >= 8'hC4 && sh <= 8'hC7) txp = 1'b1;
				if (sh == 8'h5A) dev_irq <= 1'b0;
				if (sh[7:6] == 2'h1) osh = (sh == 8'h7F) ? rx_byte : irq_val;
			end else if (hdr == 8'h80) fifo_q.push_back(sh);
			else if (hdr[7:6] == 2'h0) regs[hdr[5:0]] = sh;
			nby = nby + 8'h01;
		end
	end
	// end of transmission, then answer after the mask delay
	always @(posedge spi_cs_n) if (txp) begin
		txp = 1'b0;
		repeat (irq_dly) @(posedge clk);
		dev_irq <= 1'b1;
	end
endmodule : raf_dev_model

// >>> raf_host_ctrl_tb.sv
// Purpose: self-checking bench of the host sequencer
// Assumes: device model answers on the serial port
// Notes: guard time shortened to 20 cycles
`timescale 1ns/1ns
module raf_host_ctrl_tb;
	import raf_pkg::*;
	logic clk, rst, cmd_valid, cmd_ready, rate424, pre_hi, pre_lo, pay_valid, pay_ready;
	raf_cmd_type cmd_code;
	logic [7:0] sel_code, valid_cnt, tf_len, pay_data, rd_data, irq_val, rx_byte, irq_dly;
	logic [39:0] uid_bits;
	logic [2:0] rx_bits;
	logic done, tag_present, no_answer, sclk, mosi, cs_n, miso, dev_irq;
	int bad_count, samples_checked, i, n, s;
	raf_host_ctrl #(.GUARD_CYC(20)) dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_code(cmd_code), .sel_code(sel_code),
		.valid_cnt(valid_cnt), .uid_bits(uid_bits), .tf_len(tf_len), .rate424(rate424),
		.preamble_len_sel_hi(pre_hi), .preamble_len_sel_lo(pre_lo), .rx_bits(rx_bits),
		.pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data), .done(done),
		.tag_present(tag_present), .no_answer(no_answer), .rd_data(rd_data),
		.spi_sclk(sclk), .spi_mosi(mosi), .spi_cs_n(cs_n), .spi_miso(miso), .dev_irq(dev_irq));
	raf_dev_model dev (.clk(clk), .spi_sclk(sclk), .spi_mosi(mosi), .spi_cs_n(cs_n),
		.spi_miso(miso), .dev_irq(dev_irq), .irq_val(irq_val), .rx_byte(rx_byte),
		.irq_dly(irq_dly));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// payload offered every other cycle so the loader stalls
	always @(posedge clk) begin
		pay_valid <= ~pay_valid;
		if (pay_valid && pay_ready) pay_data <= pay_data + 8'h01;
	end
	task automatic finish_test;
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// one user command, bounded wait for its done pulse
	task automatic run(input raf_cmd_type c, input logic [7:0] dly);
		int k;
		@(posedge clk);
		cmd_code <= c;
		irq_dly <= dly;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (k = 0; k < 30000 && done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		if (k == 30000) begin
			bad_count++;
			finish_test();
		end
		chk({cmd_ready, done}, 2'h3);
		// realign so the caller drives on the rising edge
		@(posedge clk);
	endtask : run
	initial begin
		{rst, cmd_valid, rate424, pre_hi, pay_valid, bad_count, samples_checked} = '1;
		{cmd_valid, rate424, pre_hi, pre_lo, pay_valid, bad_count, samples_checked} = '0;
		{sel_code, valid_cnt, tf_len, pay_data, irq_val, rx_byte, uid_bits, rx_bits} = '0;
		cmd_code = RAF_C_SETUP;
		irq_dly = 8'h00;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		run(RAF_C_SETUP, 8'h03);
		chk({dev.regs[6'h03], dev.regs[6'h04]}, 16'h0800);
		chk({dev.regs[6'h0F], dev.regs[6'h10], dev.regs[6'h11]}, 24'h12_0015);
		chk({dev.regs[6'h02], dev.last_dc}, 16'hC8CC);
		// request and wake-up, prompt no-answer and slow tag answer
		for (i = 0; i < 2; i++) begin
			irq_val <= i ? 8'h10 : 8'h01;
			run(raf_cmd_type'(i ? 3'h2 : 3'h1), i ? 8'hC8 : 8'h03);
			chk(dev.last_dc, i ? 8'hC7 : 8'hC6);
			chk({tag_present, no_answer}, i ? 2'h2 : 2'h1);
			chk({dev.regs[6'h05], dev.regs[6'h01]}, 16'h0180);
		end
		sel_code <= 8'h93;
		valid_cnt <= 8'h23;
		uid_bits <= 40'hAB_CDEF_12FF;
		run(RAF_C_ANTICOL, 8'h03);
		chk(40'(dev.fifo_q.size()), 40'h3);
		chk({dev.fifo_q[0], dev.fifo_q[1], dev.fifo_q[2]}, 24'h93_2307);
		chk({dev.last_dc, dev.regs[6'h1E]}, 16'hC513);
		valid_cnt <= 8'h70;
		uid_bits <= 40'h11_2233_4455;
		run(RAF_C_SELECT, 8'h20);
		chk(40'(dev.fifo_q.size()), 40'h7);
		chk({dev.fifo_q[2], dev.fifo_q[6]}, 16'h5511);
		chk({dev.last_dc, dev.regs[6'h05], dev.regs[6'h01]}, 24'hC4_0000);
		// 1-byte payload at 212 kbps, 254-byte payload at 424 kbps
		for (i = 0; i < 2; i++) begin
			n = i ? 254 : 1;
			tf_len <= 8'(n);
			rate424 <= i[0];
			pre_hi <= i[0];
			pre_lo <= i[0];
			s = pay_data;
			run(RAF_C_TYPEF, 8'h05);
			chk({dev.regs[6'h03], dev.regs[6'h04]}, i ? 16'h2022 : 16'h2011);
			chk(dev.regs[6'h06], i ? 8'h03 : 8'h00);
			chk({dev.regs[6'h1D], dev.regs[6'h1E]}, {13'(n), 3'h0});
			chk(40'(dev.fifo_q.size()), 40'(n));
			chk({dev.fifo_q[0], dev.fifo_q[n - 1]}, {8'(s), 8'(s + n - 1)});
			chk(dev.last_dc, 8'hC4);
		end
		// received byte masked to its valid bits
		rx_byte <= 8'hB5;
		for (i = 0; i < 2; i++) begin
			rx_bits <= i ? 3'h0 : 3'h3;
			run(RAF_C_RDFIFO, 8'h03);
			chk(rd_data, i ? 8'hB5 : 8'h05);
		end
		finish_test();
	end
endmodule : raf_host_ctrl_tb
